// ==== hw/nisf_chan_filter.sv ====
// One channel of the consecutive-sample filter with separate high and low counts.
// Assumes the raw comparison results come qualified by a one-cycle sample strobe.
`timescale 1ns/1ps
module nisf_chan_filter #(
  parameter int unsigned CW = 8
) (
  input  wire logic          clk_sys,
  input  wire logic          rst,
  input  wire logic          smp,
  input  wire logic          want_hi,
  input  wire logic          want_lo,
  input  wire logic [CW-1:0] hi_cnt,
  input  wire logic [CW-1:0] lo_cnt,
  output logic               state_q
);
  logic [CW-1:0] run_q;

  // Run counter restarts on any sample that breaks the pending transition.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      run_q   <= '0;
      state_q <= 1'b0;
    end
    else if (smp)
    begin
      if (!state_q && want_hi)
      begin
        if (hi_cnt == '0 || run_q + 1'b1 >= hi_cnt)
        begin
          state_q <= 1'b1;
          run_q   <= '0;
        end
        else
          run_q <= run_q + 1'b1;
      end
      else if (state_q && want_lo)
      begin
        if (lo_cnt == '0 || run_q + 1'b1 >= lo_cnt)
        begin
          state_q <= 1'b0;
          run_q   <= '0;
        end
        else
          run_q <= run_q + 1'b1;
      end
      else
        run_q <= '0;
    end
  end
endmodule

// ==== hw/nisf_interval.sv ====
// Programmable interval timer giving a one-cycle tick every period+1 clocks.
// Assumes the period is a register value; zero means a tick every cycle.
`timescale 1ns/1ps
module nisf_interval #(
  parameter int unsigned W = 24
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic [W-1:0] period,
  output logic              tick
);
  logic [W-1:0] cnt_q;

  // Count up and clear; first tick only after a full interval.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end
    else if (cnt_q >= period)
    begin
      cnt_q <= '0;
      tick  <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 1'b1;
      tick  <= 1'b0;
    end
  end
endmodule

// ==== hw/nisf_pkg.sv ====
// Package for the node input sample filter: register map, field layout and reset values.
// Assumes a 32-bit APB register bus and a single 50 MHz system clock.
package nisf_pkg;
  localparam int unsigned N_DISC    = 4;
  localparam int unsigned N_ANA     = 2;
  localparam int unsigned ANA_W     = 12;
  localparam int unsigned CNT_W     = 8;
  localparam int unsigned IVL_W     = 24;
  localparam int unsigned N_CH      = N_DISC + N_ANA;
  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_SAMP_IV = 8'h04;
  localparam logic [7:0] OFF_REP_IV  = 8'h08;
  localparam logic [7:0] OFF_FILT    = 8'h0c;
  localparam logic [7:0] OFF_THRESH  = 8'h10;
  localparam logic [7:0] OFF_HYST    = 8'h14;
  localparam logic [7:0] OFF_DEMAND  = 8'h18;
  localparam logic [7:0] OFF_STATE   = 8'h1c;
  localparam logic [7:0] OFF_IRQ_ST  = 8'h20;
  localparam logic [7:0] OFF_IRQ_EN  = 8'h24;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h28;
  // Control and filter fields.
  localparam int unsigned CTRL_COS_BIT = 0;
  localparam int unsigned FILT_LO_POS  = 8;
  // Interrupt status bits.
  localparam int unsigned IRQ_REP_BIT  = 0;
  localparam int unsigned IRQ_DEM_BIT  = 1;
  localparam int unsigned IRQ_CHG_BIT  = 2;
  localparam int unsigned IRQ_W        = 3;
  // Reset values.
  localparam logic [IVL_W-1:0] SAMP_IV_RST = 24'h0000ff;
  localparam logic [IVL_W-1:0] REP_IV_RST  = 24'h000fff;
  localparam logic [ANA_W-1:0] THRESH_RST  = 12'h800;
  localparam logic [ANA_W-1:0] HYST_RST    = 12'h100;
endpackage

// ==== hw/nisf_top.sv ====
// Node input sample filter: samples inputs, filters them and raises reports.
// Assumes synchronous inputs, one clock clk_sys and an APB master for registers.
// Overview of operation
// - A discrete input turns active only after sample-high consecutive high samples.
// - A discrete input turns low only after sample-low consecutive low samples.
// - A count of zero bypasses the filter so each sample passes straight through.
// - Counts are eight-bit fields accepting 1 to 255 when enabled.
// - An analog input turns active after sample-high consecutive samples above threshold.
// - An analog input turns off after sample-low samples under threshold minus hysteresis.
// - Inputs are sampled periodically at a programmable sample interval.
// - Status is reported periodically at a separate programmable report interval.
// - In change-of-state mode periodic reports stop; a report goes out when a conditioned input changes or on demand.
// - A write to the demand register samples at once and returns the readings.
// - A demand sample does not disturb the periodic report schedule.
// - Hysteresis places the off point below the threshold, giving two switch points.
`timescale 1ns/1ps
module nisf_top
#(
  parameter int unsigned ND = nisf_pkg::N_DISC,
  parameter int unsigned NA = nisf_pkg::N_ANA
) (
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic [ND-1:0]              disc_in,
  input  wire logic [NA*nisf_pkg::ANA_W-1:0] ana_in,
  output logic      [ND+NA-1:0]           report_data,
  output logic                            report_valid,
  output logic                            irq
);
  import nisf_pkg::*;

  localparam int unsigned NC = ND + NA;

  logic [IVL_W-1:0] samp_iv_q;
  logic [IVL_W-1:0] rep_iv_q;
  logic [CNT_W-1:0] hi_cnt_q;
  logic [CNT_W-1:0] lo_cnt_q;
  logic [ANA_W-1:0] thresh_q;
  logic [ANA_W-1:0] hyst_q;
  logic             cos_q;
  logic             demand_q;
  logic [IRQ_W-1:0] irq_st_q;
  logic [IRQ_W-1:0] irq_en_q;
  logic [IRQ_W-1:0] irq_clr;
  logic             samp_tick;
  logic             rep_tick;
  logic             smp;
  logic [NC-1:0]    want_hi;
  logic [NC-1:0]    want_lo;
  logic [NC-1:0]    cond;
  logic [NC-1:0]    cond_prev_q;
  logic             chg;
  logic             acc;
  logic             wr;
  logic [ANA_W-1:0] off_pt;
  logic             smp_dly_q;
  logic             rep_due;
  logic [CNT_W-1:0] hi_run_q;
  logic [CNT_W-1:0] lo_run_q;

  // APB access phase; every transfer completes with zero wait states.
  // A transfer is therefore one setup cycle and a single access cycle.
  assign acc = psel && penable;
  assign wr  = acc && pwrite;

  // Off point saturates at zero so a large hysteresis cannot wrap around.
  assign off_pt = (hyst_q > thresh_q) ? '0 : thresh_q - hyst_q;

  // Writable configuration registers.
  // Every eight-bit count is legal, so no range check is needed; zero bypasses.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      samp_iv_q <= SAMP_IV_RST;
      rep_iv_q  <= REP_IV_RST;
      hi_cnt_q  <= '0;
      lo_cnt_q  <= '0;
      thresh_q  <= THRESH_RST;
      hyst_q    <= HYST_RST;
      cos_q     <= 1'b0;
      irq_en_q  <= '0;
    end
    else if (wr)
    begin
      case (paddr)
        OFF_CTRL:    cos_q     <= pwdata[CTRL_COS_BIT];
        OFF_SAMP_IV: samp_iv_q <= pwdata[IVL_W-1:0];
        OFF_REP_IV:  rep_iv_q  <= pwdata[IVL_W-1:0];
        OFF_FILT:
        begin
          hi_cnt_q <= pwdata[CNT_W-1:0];
          lo_cnt_q <= pwdata[FILT_LO_POS +: CNT_W];
        end
        OFF_THRESH:  thresh_q  <= pwdata[ANA_W-1:0];
        OFF_HYST:    hyst_q    <= pwdata[ANA_W-1:0];
        OFF_IRQ_EN:  irq_en_q  <= pwdata[IRQ_W-1:0];
        default:     cos_q     <= cos_q;
      endcase
    end
  end

  // Demand strobe lasts one cycle after the write to its register.
  // Registering it keeps the sample a full cycle away from the bus decode.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      demand_q <= 1'b0;
    else
      demand_q <= wr && (paddr == OFF_DEMAND);
  end

  // The clear mask is live only in the write cycle of its register.
  assign irq_clr = (wr && paddr == OFF_IRQ_CLR) ? pwdata[IRQ_W-1:0] : '0;

  // Read mux; unmapped addresses read zero and flag an error.
  // Data are launched in the setup cycle so they stand while pready is high.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= '0;
      if (psel && !penable)
      begin
        case (paddr)
          OFF_CTRL:    prdata <= 32'(cos_q);
          OFF_SAMP_IV: prdata <= 32'(samp_iv_q);
          OFF_REP_IV:  prdata <= 32'(rep_iv_q);
          OFF_FILT:    prdata <= 32'({lo_cnt_q, hi_cnt_q});
          OFF_THRESH:  prdata <= 32'(thresh_q);
          OFF_HYST:    prdata <= 32'(hyst_q);
          OFF_DEMAND:  prdata <= 32'h0000_0000;
          OFF_STATE:   prdata <= 32'(cond);
          OFF_IRQ_ST:  prdata <= 32'(irq_st_q);
          OFF_IRQ_EN:  prdata <= 32'(irq_en_q);
          OFF_IRQ_CLR: prdata <= 32'h0000_0000;
          default:     pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Separate sample and report timers so demand never shifts the schedule.
  // The report timer runs free; only reset and interval writes move its phase.
  nisf_interval #(.W(IVL_W)) u_samp_iv (
    .clk_sys (clk_sys),
    .rst     (rst),
    .period  (samp_iv_q),
    .tick    (samp_tick)
  );
  nisf_interval #(.W(IVL_W)) u_rep_iv (
    .clk_sys (clk_sys),
    .rst     (rst),
    .period  (rep_iv_q),
    .tick    (rep_tick)
  );

  // A sample happens on the periodic tick or on demand.
  // A demand that meets a periodic tick makes only one sample.
  assign smp = samp_tick || demand_q;

  // Raw comparisons per channel; discrete follow the pin, analog use two points.
  // The threshold and off point are shared by every analog channel.
  genvar g;
  generate
    for (g = 0; g < NC; g++)
    begin : g_ch
      if (g < ND)
      begin : g_disc
        assign want_hi[g] = disc_in[g];
        assign want_lo[g] = !disc_in[g];
      end
      else
      begin : g_ana
        logic [ANA_W-1:0] v;
        assign v          = ana_in[(g-ND)*ANA_W +: ANA_W];
        assign want_hi[g] = v > thresh_q;
        assign want_lo[g] = v < off_pt;
      end
      nisf_chan_filter #(.CW(CNT_W)) u_filt (
        .clk_sys (clk_sys),
        .rst     (rst),
        .smp     (smp),
        .want_hi (want_hi[g]),
        .want_lo (want_lo[g]),
        .hi_cnt  (hi_cnt_q),
        .lo_cnt  (lo_cnt_q),
        .state_q (cond[g])
      );
    end
  endgenerate

  // Change detection compares with the states of the previous cycle.
  // The view follows the states every cycle, so each change is seen once.
  assign chg = cond != cond_prev_q;

  // Report path: one-cycle valid with data from a register.
  // A change that meets a demand or periodic report goes out as one report,
  // which trades a separate change report for a simpler gateway side.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      smp_dly_q    <= 1'b0;
      cond_prev_q  <= '0;
      report_valid <= 1'b0;
      report_data  <= '0;
      rep_due      <= 1'b0;
    end
    else
    begin
      smp_dly_q    <= demand_q;
      report_valid <= 1'b0;
      cond_prev_q  <= cond;
      rep_due      <= rep_tick && !cos_q;
      if (smp_dly_q || rep_due || (cos_q && chg))
      begin
        report_valid <= 1'b1;
        report_data  <= cond;
      end
    end
  end

  // Sticky status; a set in the clear cycle wins.
  // Each event lasts one cycle, so the status keeps it until software clears it.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      irq_st_q <= '0;
    else
    begin
      irq_st_q <= (irq_st_q & ~irq_clr)
                | {chg, smp_dly_q, rep_due};
    end
  end

  // Interrupt level is registered to keep the output glitch free.
  // The level therefore lags the status by one cycle.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(irq_st_q & irq_en_q);
  end

  // Reference run lengths for channel 0, counted apart from the filter so that
  // the run assertions below do not restate the filter's own counter.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      hi_run_q <= '0;
      lo_run_q <= '0;
    end
    else if (smp)
    begin
      if (!want_hi[0])
        hi_run_q <= '0;
      else if (hi_run_q != '1)
        hi_run_q <= hi_run_q + 1'b1;
      if (!want_lo[0])
        lo_run_q <= '0;
      else if (lo_run_q != '1)
        lo_run_q <= lo_run_q + 1'b1;
    end
  end

  // Report causes and scheduling; nothing reports without a cause after reset.
  no_rpt_a : assert property (@(posedge clk_sys) disable iff (rst)
    $rose(report_valid) |-> $past(smp_dly_q) || $past(rep_due) || $past(cos_q && chg))
    else $error("Report without cause.");
  dem_rpt_a : assert property (@(posedge clk_sys) disable iff (rst)
    demand_q |-> ##2 report_valid)
    else $error("Demand not reported.");
  rpt_data_a : assert property (@(posedge clk_sys) disable iff (rst)
    report_valid |-> report_data == $past(cond))
    else $error("Report data stale.");
  per_rpt_a : assert property (@(posedge clk_sys) disable iff (rst)
    rep_due |=> report_valid)
    else $error("Periodic report missing.");
  cos_only_a : assert property (@(posedge clk_sys) disable iff (rst)
    (cos_q && $past(cos_q) && !chg && !smp_dly_q) |=> !report_valid)
    else $error("Report in change mode without a change.");
  dem_sched_a : assert property (@(posedge clk_sys) disable iff (rst)
    (demand_q && u_rep_iv.cnt_q < rep_iv_q)
    |=> u_rep_iv.cnt_q == $past(u_rep_iv.cnt_q) + 1'b1)
    else $error("Schedule disturbed.");

  // Filter runs, bypass and hold between samples.
  run_hi_a : assert property (@(posedge clk_sys) disable iff (rst)
    $rose(cond[0]) |-> hi_cnt_q == '0 || hi_run_q >= hi_cnt_q)
    else $error("Input rose before its high run was complete.");
  run_lo_a : assert property (@(posedge clk_sys) disable iff (rst)
    $fell(cond[0]) |-> lo_cnt_q == '0 || lo_run_q >= lo_cnt_q)
    else $error("Input fell before its low run was complete.");
  bypass_a : assert property (@(posedge clk_sys) disable iff (rst)
    (smp && hi_cnt_q == '0 && !cond[0] && want_hi[0]) |=> cond[0])
    else $error("Zero count not bypassed.");
  low_by_a : assert property (@(posedge clk_sys) disable iff (rst)
    (smp && lo_cnt_q == '0 && cond[0] && want_lo[0]) |=> !cond[0])
    else $error("Zero low count not bypassed.");
  no_smp_a : assert property (@(posedge clk_sys) disable iff (rst)
    !smp |=> $stable(cond))
    else $error("State moved without sample.");

  // Analog hold band, interrupt level and bus answer.
  hyst_a : assert property (@(posedge clk_sys) disable iff (rst)
    (smp && cond[ND] && {1'b0, ana_in[ANA_W-1:0]} + {1'b0, hyst_q} >= {1'b0, thresh_q})
    |=> cond[ND])
    else $error("Analog input dropped inside the hysteresis band.");
  irq_lvl_a : assert property (@(posedge clk_sys) disable iff (rst)
    |(irq_st_q & irq_en_q) |=> irq)
    else $error("Interrupt not raised.");
  apb_rdy_a : assert property (@(posedge clk_sys) disable iff (rst)
    (psel && !penable) |=> pready)
    else $error("Bus access not answered.");

  // Covers for the main scenarios.
  dem_c : cover property (@(posedge clk_sys) disable iff (rst) demand_q ##2 report_valid);
  per_c : cover property (@(posedge clk_sys) disable iff (rst) rep_due ##1 report_valid);
  cos_c : cover property (@(posedge clk_sys) disable iff (rst) cos_q && chg);
  filt_c : cover property (@(posedge clk_sys) disable iff (rst) hi_cnt_q != '0 && $rose(cond[0]));
  hyst_c : cover property (@(posedge clk_sys) disable iff (rst)
    smp && cond[ND] && !want_hi[ND] && !want_lo[ND]);
endmodule

// ==== testbench/nisf_gw_model.sv ====
// Gateway model: takes every report pulse and keeps its count, data and time.
// Assumes report_valid is a one-cycle pulse in the clk_sys domain.
`timescale 1ns/1ps
module nisf_gw_model (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [5:0] report_data,
  input  wire logic       report_valid,
  output int              n_rep,
  output logic [5:0]      last_data,
  output int              last_t
);
  int cyc;
  // Each report is taken whole in its pulse cycle, so a report is never missed or doubled.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cyc <= 0;
      n_rep <= 0;
      last_data <= 6'h00;
      last_t <= 0;
    end
    else
    begin
      cyc <= cyc + 1;
      if (report_valid === 1'b1)
      begin
        n_rep <= n_rep + 1;
        last_data <= report_data;
        last_t <= cyc;
      end
    end
  end
endmodule

// ==== testbench/tb_node_input_sample_filter.sv ====
// Self-checking bench for the node input sample filter.
// Assumes the design answers APB on the cycle after setup and a gateway model on the reports.
`timescale 1ns/1ps
module tb_node_input_sample_filter;
  import nisf_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr, report_valid, irq, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  disc_in;
  logic [23:0] ana_in;
  logic [5:0]  report_data, last_data;
  int          n_rep, last_t, n_mismatch, checked, t0;

  nisf_top u_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .disc_in(disc_in), .ana_in(ana_in), .report_data(report_data),
    .report_valid(report_valid), .irq(irq));
  nisf_gw_model u_gw (.clk_sys(clk_sys), .rst(rst), .report_data(report_data),
    .report_valid(report_valid), .n_rep(n_rep), .last_data(last_data), .last_t(last_t));

  // The clock toggles every half period of 10 ns.
  always #10 clk_sys = ~clk_sys;

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Only the watchdog ends a wait for an answer that never comes.
    do
    begin
      @(posedge clk_sys);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
  task automatic rdr(input logic [7:0] a); apb(1'b0, a, 32'h0); endtask
  task automatic cyc(input int n); repeat (n) @(posedge clk_sys); endtask

  // Waits a bounded time for one new report; a missing report counts as a mismatch.
  task automatic wait_rep();
    int n0, k;
    n0 = n_rep;
    k = 0;
    while (n_rep == n0 && k < 40)
    begin
      @(posedge clk_sys);
      k++;
    end
    chk(32'(n_rep - n0), 32'h1);
  endtask

  task automatic demand(); wr(OFF_DEMAND, 32'h0); wait_rep(); endtask

  task automatic t_reset();
    logic [7:0]  a[6] = '{OFF_CTRL, OFF_SAMP_IV, OFF_REP_IV, OFF_FILT, OFF_THRESH, OFF_HYST};
    logic [31:0] e[6] = '{32'h0, 32'hff, 32'hfff, 32'h0, 32'h800, 32'h100};
    chk(32'(n_rep), 32'h0);
    rdr(OFF_STATE); chk(rd, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      rdr(a[i]); chk(rd, e[i]);
    end
    rdr(8'h40); chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    wr(OFF_FILT, 32'hffff); rdr(OFF_FILT); chk(rd, 32'hffff);
    wr(OFF_FILT, 32'h0);
  endtask

  task automatic t_irq();
    disc_in <= 4'h9;
    wr(OFF_IRQ_EN, 32'h2);
    demand(); chk({26'h0, last_data}, 32'h9);
    cyc(3); chk({31'h0, irq}, 32'h1);
    rdr(OFF_IRQ_ST); chk(rd & 32'h2, 32'h2);
    wr(OFF_IRQ_CLR, 32'h7); cyc(3); chk({31'h0, irq}, 32'h0);
    wr(OFF_IRQ_EN, 32'h0);
    demand(); cyc(3); chk({31'h0, irq}, 32'h0);
    rdr(OFF_IRQ_ST); chk(rd & 32'h2, 32'h2);
    wr(OFF_IRQ_CLR, 32'h7);
  endtask

  // Demand writes are the only samples here, so each one advances the run count by one or restarts it.
  task automatic t_filter();
    logic [3:0] v[9] = '{4'h0, 4'h5, 4'h5, 4'h0, 4'h5, 4'h5, 4'h5, 4'h0, 4'h0};
    logic [3:0] e[9] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h5, 4'h5, 4'h0};
    // Clear the states left high by the interrupt scenario while still bypassed.
    disc_in <= 4'h0;
    demand();
    wr(OFF_FILT, 32'h0203);
    for (int i = 0; i < 9; i++)
    begin
      disc_in <= v[i];
      demand();
      rdr(OFF_STATE); chk(rd, {28'h0, e[i]});
    end
    wr(OFF_FILT, 32'h0);
  endtask

  task automatic t_analog();
    logic [11:0] v[6] = '{12'h801, 12'h700, 12'h6ff, 12'h800, 12'h801, 12'h0};
    logic        e[6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    disc_in <= 4'h0;
    for (int i = 0; i < 6; i++)
    begin
      ana_in <= {12'h0, v[i]};
      demand();
      rdr(OFF_STATE); chk(rd, {27'h0, e[i], 4'h0});
    end
  endtask

  task automatic t_periodic();
    wr(OFF_REP_IV, 32'h9);
    wait_rep(); wait_rep(); t0 = last_t;
    wait_rep(); chk(32'(last_t - t0), 32'ha);
    t0 = last_t;
    wr(OFF_DEMAND, 32'h0);
    wait_rep();
    wait_rep(); chk(32'(last_t - t0), 32'ha);
  endtask

  task automatic t_cos();
    int n0;
    wr(OFF_SAMP_IV, 32'h3);
    wr(OFF_CTRL, 32'h1);
    cyc(30); n0 = n_rep;
    cyc(60); chk(32'(n_rep - n0), 32'h0);
    disc_in <= 4'ha;
    wait_rep(); chk({26'h0, last_data}, 32'ha);
  endtask

  // A hang ends the run through the same closing task.
  initial
  begin
    repeat (40000) @(posedge clk_sys);
    n_mismatch++;
    conclude();
  end

  // Main sequence: reset, then one scenario after another.
  initial
  begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    disc_in = 4'h0; ana_in = 24'h0; n_mismatch = 0; checked = 0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    // Long intervals keep stray periodic samples out of the counted runs.
    wr(OFF_SAMP_IV, 32'hffffff);
    wr(OFF_REP_IV, 32'hffffff);
    cyc(4200);
    chk(32'(n_rep), 32'h0);
    t_irq();
    t_filter();
    t_analog();
    t_periodic();
    t_cos();
    conclude();
  end
endmodule
